// ===== src/i2cst_status.sv
// Status tracker of an I2C master: ack, ten-bit, direction, shift phases, nack irq.
// Assumes scl_clk is the serial link clock, free running, unrelated to mclk.
// Summary of operation
// [RULE1] Ack flag sets when the last byte was acknowledged.
// [RULE2] Ack flag clears when disabled or the last byte was not acknowledged.
// [RULE3] Ack flag survives new transactions and status reads.
// [RULE4] Writes stall at ack cycle while transmit data empty and no start/stop.
// [RULE5] Ten-bit flag sets on header 11110 after start, clears after first byte.
// [RULE6] Read flag takes shift register bit 0 once start is requested.
// [RULE7] Address shift flag high exactly while the address byte shifts.
// [RULE8] Data shift flag high exactly while a data byte shifts.
// [RULE9] Nack interrupt sets on a nack while neither start nor stop active.
// [RULE10] Nack interrupt clears only when software sets start or stop.
// [RULE11] Serial clock is driven open-drain; the code holds scl_oe low, so the clock is never driven.
// [RULE12] Serial data is open-drain in both directions.
// [RULE13] All flags are zero after reset.
`timescale 1ns/1ps
module i2cst_status
    import i2cst_pkg::*;
(
    input wire logic mclk, // System clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic scl_clk, // Link clock, one edge per bit.
    input wire i2cst_pkg::i2cst_ctrl_s ctrl, // Software control bits.
    input wire logic [7:0] shift_load, // Byte loaded into the shift register.
    input wire logic sda_in, // Data line level.
    output logic scl_out, // Clock line output value, always low.
    output logic scl_oe, // Clock line pull-down enable.
    output logic sda_out, // Data line output value, always low.
    output logic sda_oe, // Data line pull-down enable.
    output i2cst_pkg::i2cst_stat_s stat, // Status flags.
    output logic irq // Nack interrupt request.
);
    import i2cst_pkg::*;

    // Control crossing into the link domain: two flops each.
    logic [3:0] ctl_s1_r, ctl_s2_r;
    always_ff @(posedge scl_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctl_s1_r <= 4'h0;
            ctl_s2_r <= 4'h0;
        end
        else
        begin
            ctl_s1_r <= ctrl;
            ctl_s2_r <= ctl_s1_r;
        end
    end
    wire l_en = ctl_s2_r[3];
    wire l_start = ctl_s2_r[2];
    wire l_stop = ctl_s2_r[1];
    wire l_tde = ctl_s2_r[0];

    // Link-side state machine and shift register.
    i2cst_phase_e phase_r;
    logic [7:0] sh_r;
    logic [3:0] bit_r;
    logic first_r, is_rd_r, ack_r, ack_tg_r, nack_tg_r, drive_r;
    always_ff @(posedge scl_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase_r <= I2CST_IDLE;
            sh_r <= 8'h00;
            bit_r <= 4'h0;
            first_r <= 1'b0;
            is_rd_r <= 1'b0;
            ack_r <= 1'b0; // RULE13
            ack_tg_r <= 1'b0;
            nack_tg_r <= 1'b0;
            drive_r <= 1'b0;
        end
        else
        begin
            case (phase_r)
                I2CST_IDLE:
                begin
                    drive_r <= 1'b0;
                    if (l_en && l_start)
                    begin
                        sh_r <= shift_load;
                        is_rd_r <= shift_load[0];
                        // The first address bit must already stand at the first sampling edge.
                        drive_r <= !shift_load[7]; // RULE12
                        bit_r <= 4'h0;
                        first_r <= 1'b1;
                        phase_r <= I2CST_ADDR;
                    end
                end
                I2CST_ADDR, I2CST_DATA:
                begin
                    // Each edge samples the bit in flight and puts out the next one.
                    // The line therefore moves at the very edge that samples it.
                    // Reads release the line. After the last bit the master lets go for
                    // the slave's ack, or pulls low itself to acknowledge read data.
                    if (bit_r == I2CST_BYTE_BITS - 4'h1)
                        drive_r <= (phase_r == I2CST_DATA) && is_rd_r; // RULE12
                    else
                        drive_r <= (phase_r == I2CST_ADDR || !is_rd_r) && !sh_r[6]; // RULE12
                    sh_r <= {sh_r[6:0], sda_in};
                    bit_r <= bit_r + 4'h1;
                    if (bit_r == I2CST_BYTE_BITS - 4'h1)
                    begin
                        // A write with nothing queued stalls before the ack cycle.
                        if (!is_rd_r && l_tde && !l_start && !l_stop) // RULE4
                            phase_r <= I2CST_HOLD;
                        else
                            phase_r <= I2CST_ACKC;
                    end
                end
                I2CST_HOLD:
                begin
                    if (!l_tde || l_start || l_stop) // RULE4
                        phase_r <= I2CST_ACKC;
                end
                I2CST_ACKC:
                begin
                    ack_r <= !sda_in; // RULE1 RULE2
                    ack_tg_r <= ~ack_tg_r;
                    if (sda_in)
                        nack_tg_r <= ~nack_tg_r;
                    first_r <= 1'b0;
                    bit_r <= 4'h0;
                    sh_r <= shift_load;
                    if (sda_in || l_stop || !l_en)
                    begin
                        phase_r <= I2CST_IDLE;
                        drive_r <= 1'b0;
                    end
                    else
                    begin
                        phase_r <= I2CST_DATA;
                        drive_r <= !is_rd_r && !shift_load[7]; // RULE12
                    end
                end
                default: phase_r <= I2CST_IDLE;
            endcase
        end
    end

    // Phase and flag levels cross back into the system domain.
    logic [4:0] st_s1_r, st_s2_r;
    logic [2:0] tg_s3_r;
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_s1_r <= 5'h00;
            st_s2_r <= 5'h00;
            tg_s3_r <= 3'h0;
        end
        else
        begin
            st_s1_r <= {phase_r == I2CST_ADDR, phase_r == I2CST_DATA, first_r, ack_tg_r,
                nack_tg_r};
            st_s2_r <= st_s1_r;
            tg_s3_r <= {st_s2_r[2], st_s2_r[1], st_s2_r[0]};
        end
    end
    wire ack_evt = st_s2_r[1] ^ tg_s3_r[1];
    wire nack_evt = st_s2_r[0] ^ tg_s3_r[0];
    wire first_done = tg_s3_r[2] && !st_s2_r[2];

    // Start request edge, for the ten-bit and read flags.
    logic start_d_r;
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            start_d_r <= 1'b0;
        else
            start_d_r <= ctrl.start;
    end
    wire start_rise = ctrl.start && !start_d_r;

    // Status flags; reads have no side effect since there is no read strobe.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            stat <= I2CST_STAT_RST; // RULE13
        else
        begin
            if (!ctrl.controller_enable)
                stat.ack <= 1'b0; // RULE2
            else if (ack_evt)
                stat.ack <= ack_r; // RULE1 RULE3
            if (start_rise && shift_load[7:3] == I2CST_TEN_BIT_HDR)
                stat.ten_bit_addr_flag <= 1'b1; // RULE5
            else if (first_done)
                stat.ten_bit_addr_flag <= 1'b0; // RULE5
            if (start_rise)
                stat.rd <= shift_load[0]; // RULE6
            stat.addr_shift_state <= st_s2_r[4]; // RULE7
            stat.data_shift_state <= st_s2_r[3]; // RULE8
            // A clear by start or stop wins over a simultaneous nack.
            if (nack_evt && !ctrl.start && !ctrl.stop)
                stat.nack_interrupt_flag <= 1'b1; // RULE9
            else if (ctrl.start || ctrl.stop)
                stat.nack_interrupt_flag <= 1'b0; // RULE10
        end
    end

    // Interrupt mirrors the nack flag, registered.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            irq <= 1'b0;
        else
            irq <= (nack_evt && !ctrl.start && !ctrl.stop)
                || (stat.nack_interrupt_flag && !ctrl.start && !ctrl.stop);
    end

    // Open-drain pins: the output values are always low; only sda_oe moves, scl_oe stays low.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            scl_out <= 1'b0;
            scl_oe <= 1'b0;
            sda_out <= 1'b0;
        end
        else
        begin
            scl_out <= 1'b0; // RULE11
            scl_oe <= 1'b0; // RULE11
            sda_out <= 1'b0; // RULE12
        end
    end

    // Data line enable comes straight from the link-domain flop.
    // It moves with the bit timing and never waits for a crossing into mclk.
    assign sda_oe = drive_r; // RULE12

    // An address byte takes exactly eight link edges, then the phase moves on.
    sequence s_addr_byte;
        (phase_r == I2CST_ADDR)[*8] ##1 (phase_r != I2CST_ADDR);
    endsequence

    // Checks.
    a_nack_clear: assert property (@(posedge mclk) disable iff (!nrst) // RULE10
        $fell(stat.nack_interrupt_flag) |-> $past(ctrl.start || ctrl.stop))
        else $error("nack flag cleared without start or stop");
    a_nack_set: assert property (@(posedge mclk) disable iff (!nrst) // RULE9
        (nack_evt && !ctrl.start && !ctrl.stop) |=> stat.nack_interrupt_flag)
        else $error("nack flag not set");
    a_ack_off: assert property (@(posedge mclk) disable iff (!nrst) // RULE2
        !ctrl.controller_enable |=> !stat.ack)
        else $error("ack flag not cleared when disabled");
    a_ack_hold: assert property (@(posedge mclk) disable iff (!nrst) // RULE3
        (ctrl.controller_enable && !ack_evt) |=> $stable(stat.ack))
        else $error("ack flag changed without ack cycle");
    a_ten_set: assert property (@(posedge mclk) disable iff (!nrst) // RULE5
        (start_rise && shift_load[7:3] == I2CST_TEN_BIT_HDR) |=> stat.ten_bit_addr_flag)
        else $error("ten-bit flag not set");
    a_rd_take: assert property (@(posedge mclk) disable iff (!nrst) // RULE6
        start_rise |=> stat.rd == $past(shift_load[0]))
        else $error("read flag wrong");
    a_tas_track: assert property (@(posedge scl_clk) disable iff (!nrst) // RULE7
        $rose(phase_r == I2CST_ADDR) |-> s_addr_byte)
        else $error("address phase not eight bits long");
    a_dss_excl: assert property (@(posedge mclk) disable iff (!nrst) // RULE8
        !(stat.addr_shift_state && stat.data_shift_state))
        else $error("both shift flags high");
    a_hold_stall: assert property (@(posedge scl_clk) disable iff (!nrst) // RULE4
        (phase_r == I2CST_HOLD && l_tde && !l_start && !l_stop) |=> phase_r == I2CST_HOLD)
        else $error("stall left early");
    a_ack_release: assert property (@(posedge scl_clk) disable iff (!nrst) // RULE12
        ((phase_r == I2CST_ACKC || phase_r == I2CST_HOLD) && !is_rd_r) |-> !drive_r)
        else $error("data line held during write ack cycle");
endmodule // i2cst_status

// ===== src/i2cst_pkg.sv
// Package for the I2C master status-tracking block.
// Assumes a system clock of 25 MHz and a separate serial-link clock domain.
package i2cst_pkg;
    // System clock period in nanoseconds.
    localparam int I2CST_MCLK_NS = 40;
    // Top five bits of a ten-bit address header.
    localparam logic [4:0] I2CST_TEN_BIT_HDR = 5'h1E;
    // Bit positions of the packed status flags.
    localparam int I2CST_ACK_POS = 5;
    localparam int I2CST_TEN_POS = 4;
    localparam int I2CST_RD_POS = 3;
    localparam int I2CST_TAS_POS = 2;
    localparam int I2CST_DSS_POS = 1;
    localparam int I2CST_NCK_POS = 0;
    // Reset value of the status flags.
    localparam logic [5:0] I2CST_STAT_RST = 6'h00;
    // Bits per byte on the bus.
    localparam logic [3:0] I2CST_BYTE_BITS = 4'h8;

    // Link-side phase of the byte engine.
    typedef enum logic [2:0] {
        I2CST_IDLE = 3'b000,
        I2CST_ADDR = 3'b001,
        I2CST_DATA = 3'b010,
        I2CST_ACKC = 3'b011,
        I2CST_HOLD = 3'b100
    } i2cst_phase_e;

    // Control bits supplied by software.
    typedef struct packed {
        logic controller_enable;
        logic start;
        logic stop;
        logic tx_data_empty;
    } i2cst_ctrl_s;

    // Status flags presented to software.
    typedef struct packed {
        logic ack;
        logic ten_bit_addr_flag;
        logic rd;
        logic addr_shift_state;
        logic data_shift_state;
        logic nack_interrupt_flag;
    } i2cst_stat_s;
endpackage

// ===== dv/i2cst_slave.sv
// Model of an I2C slave on the open-drain data line.
// Assumes the bench raises ack_en while the slave should acknowledge.
`timescale 1ns/1ps
module i2cst_slave
(
    input wire logic ack_en, // Slave pulls the line low to acknowledge.
    input wire logic sda_oe, // Master pull-down enable.
    input wire logic sda_out, // Master output value.
    output logic sda // Resolved line level.
);
    // Wired-and of both pull-downs; the pull-up gives 1 once both release.
    assign sda = (ack_en || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
endmodule // i2cst_slave

// ===== dv/tb.sv
// Testbench for the I2C status tracker, one task per scenario.
// Assumes the slave model resolves the data line and scl_clk runs free.
`timescale 1ns/1ps
module tb;
    import i2cst_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic scl_clk = 1'b0;
    i2cst_ctrl_s ctrl = '0;
    logic [7:0] shift_load = 8'h00;
    logic ack_en = 1'b0;
    logic sda, scl_out, scl_oe, sda_out, sda_oe, irq;
    i2cst_stat_s stat;
    logic [5:0] sv;
    int n_fail = 0;
    int checked = 0;
    assign sv = stat;

    // The link clock is offset so its edges never meet the system clock's.
    initial
    begin
        forever #20 mclk = ~mclk;
    end
    initial
    begin
        #7;
        forever #15 scl_clk = ~scl_clk;
    end

    i2cst_status u_i2cst_status (.mclk(mclk), .nrst(nrst), .scl_clk(scl_clk), .ctrl(ctrl),
        .shift_load(shift_load), .sda_in(sda), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_out(sda_out), .sda_oe(sda_oe), .stat(stat), .irq(irq));
    i2cst_slave u_i2cst_slave (.ack_en(ack_en), .sda_oe(sda_oe), .sda_out(sda_out), .sda(sda));

    // Inputs always move 2 ns after the mclk edge, clear of the mclk flops but on a scl_clk rising edge every 120 ns.
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic chk(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %0t flag mismatch", $time);
        end
    endtask
    // Bounded wait; a timeout shows up as a mismatch.
    task automatic wait_flag(input int pos, input logic v);
        int k;
        k = 0;
        while (sv[pos] !== v && k < 300)
        begin
            cyc(1);
            k++;
        end
        chk(sv[pos], v);
    endtask
    task automatic pulse_start(input logic [7:0] b);
        shift_load = b;
        ctrl.start = 1'b1;
        cyc(1);
        ctrl.start = 1'b0;
        cyc(1);
    endtask
    task automatic t_reset();
        chk(sv === I2CST_STAT_RST, 1'b1);
        chk(irq, 1'b0);
        chk(scl_out | sda_out, 1'b0);
        chk(scl_oe | sda_oe, 1'b0);
    endtask
    task automatic t_ten_read();
        ack_en = 1'b1;
        pulse_start({I2CST_TEN_BIT_HDR, 3'h1});
        chk(sv[I2CST_TEN_POS], 1'b1);
        chk(sv[I2CST_RD_POS], 1'b1);
        wait_flag(I2CST_TAS_POS, 1'b1);
        wait_flag(I2CST_TAS_POS, 1'b0);
        cyc(6);
        chk(sv[I2CST_TEN_POS], 1'b0);
        wait_flag(I2CST_ACK_POS, 1'b1);
    endtask
    task automatic t_disable();
        pulse_start(8'h51);
        chk(sv[I2CST_ACK_POS], 1'b1);
        ctrl.controller_enable = 1'b0;
        wait_flag(I2CST_ACK_POS, 1'b0);
        // Stay disabled long enough for the link to drop back to idle.
        cyc(20);
        chk(sv[I2CST_ACK_POS], 1'b0);
        ctrl.controller_enable = 1'b1;
        cyc(40);
    endtask
    task automatic t_write_stall();
        pulse_start(8'hA0);
        chk(sv[I2CST_RD_POS], 1'b0);
        chk(sv[I2CST_TEN_POS], 1'b0);
        wait_flag(I2CST_TAS_POS, 1'b1);
        wait_flag(I2CST_TAS_POS, 1'b0);
        wait_flag(I2CST_DSS_POS, 1'b1);
        wait_flag(I2CST_ACK_POS, 1'b1);
        // The slave keeps acking until the engine is parked, so no byte is nacked early.
        ctrl.tx_data_empty = 1'b1;
        cyc(20);
        ack_en = 1'b0;
        cyc(60);
        chk(sv[I2CST_ACK_POS], 1'b1);
        chk(sv[I2CST_NCK_POS], 1'b0);
        chk(sv[I2CST_DSS_POS], 1'b0);
        chk(sda_oe, 1'b0);
        ctrl.tx_data_empty = 1'b0;
        wait_flag(I2CST_NCK_POS, 1'b1);
        chk(sv[I2CST_ACK_POS], 1'b0);
        cyc(20);
        chk(irq, 1'b1);
        chk(sv[I2CST_NCK_POS], 1'b1);
        ctrl.stop = 1'b1;
        wait_flag(I2CST_NCK_POS, 1'b0);
        ctrl.stop = 1'b0;
    endtask

    task automatic close_out();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog: the scenarios take well under 2000 system cycles.
    initial
    begin
        #(I2CST_MCLK_NS * 5000);
        n_fail++;
        close_out();
    end
    // Main sequence: reset for 4 cycles, then the scenarios in turn.
    initial
    begin
        cyc(4);
        nrst = 1'b1;
        ctrl.controller_enable = 1'b1;
        cyc(3);
        t_reset();
        t_ten_read();
        t_disable();
        t_write_stall();
        close_out();
    end
endmodule // tb
